// file: inc/sbc_pkg.sv
// Constants, types and encodings shared by the two-wire client port.
// Assumes a 50 MHz system clock and an 8 MHz free-running link clock.
package sbc_pkg;

    // Client address, received most significant bit first
    localparam logic [6:0] CLIENT_ADDR = 7'h28;

    // Clock rates
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int LINK_CLK_HZ = 8_000_000;

    // Bus timeouts in their own units
    localparam int TIMEOUT_LOW_MS = 30;
    localparam int IDLE_HIGH_US = 200;

    // Timeouts in link clock cycles (exact at 8 MHz)
    localparam int TIMEOUT_LOW_CYC = TIMEOUT_LOW_MS * (LINK_CLK_HZ / 1_000);
    localparam int IDLE_HIGH_CYC = IDLE_HIGH_US * (LINK_CLK_HZ / 1_000_000);

    // Byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // Reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Write buffer depth
    localparam int FIFO_DEPTH = 16;

    // Protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDAT,
        ST_WDAT_ACK,
        ST_RDAT,
        ST_RACK,
        ST_IGNORE
    } sbc_state_e;

    // One register write: pointer and data
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } sbc_wr_s;

endpackage : sbc_pkg

// file: rtl/sbc_client.sv
// Two-wire client port with dual-clock write buffer.
// Assumes an external pull-up on both bus lines and a free-running link clock.
`timescale 1ns/1ps

// Dual-clock FIFO with gray-coded pointers
module sbc_afifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Write side
    input wire logic wclk_i,
    input wire logic wrst_n_i,
    input wire logic wce_i,
    input wire logic w_valid_i,
    output logic w_ready_o,
    input wire logic [WIDTH-1:0] w_data_i,
    // Read side
    input wire logic rclk_i,
    input wire logic rrst_n_i,
    input wire logic rce_i,
    output logic r_valid_o,
    input wire logic r_ready_i,
    output logic [WIDTH-1:0] r_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] next_wbin, next_rbin;
    logic [AW:0] rg_meta, rg_sync, wg_meta, wg_sync;
    logic do_wr, do_rd;

    always_comb
    begin
        w_ready_o = (wgray != {~rg_sync[AW:AW-1], rg_sync[AW-2:0]});
        r_valid_o = (rgray != wg_sync);
        do_wr = wce_i && w_valid_i && w_ready_o;
        do_rd = rce_i && r_valid_o && r_ready_i;
        next_wbin = do_wr ? wbin + 1'b1 : wbin;
        next_rbin = do_rd ? rbin + 1'b1 : rbin;
        r_data_o = mem[rbin[AW-1:0]];
    end

    always_ff @(posedge wclk_i)
    begin
        if (do_wr)
        begin
            mem[wbin[AW-1:0]] <= w_data_i;
        end
        rg_meta <= rgray;
        rg_sync <= rg_meta;
        if (!wrst_n_i)
        begin
            wbin <= '0;
            wgray <= '0;
        end
        else
        begin
            wbin <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
        end
    end

    always_ff @(posedge rclk_i)
    begin
        wg_meta <= wgray;
        wg_sync <= wg_meta;
        if (!rrst_n_i)
        begin
            rbin <= '0;
            rgray <= '0;
        end
        else
        begin
            rbin <= next_rbin;
            rgray <= next_rbin ^ (next_rbin >> 1);
        end
    end
endmodule : sbc_afifo

// Functional notes
// - Start: data falls while clock high
// - First byte: seven-bit address plus direction
// - Direction zero writes, one reads
// - Answer only the fixed client address
// - Eight-bit bytes, most significant bit first
// - Acknowledge each received byte in ninth slot, except a write byte while the buffer is full
// - Stop: data rises while clock high
// - Stop returns protocol to idle
// - Never drive clock; tolerate host stretching
// - Clock low 30 ms resets port
// - Timeouts off unless enable set
// - Lines high over 200 us reset port
// - Pointer increments per byte, wraps
// - First write byte loads pointer
module sbc_client #(
    parameter int TIMEOUT_LOW_CYC = sbc_pkg::TIMEOUT_LOW_CYC,
    parameter int FIFO_DEPTH = sbc_pkg::FIFO_DEPTH
) (
    // System clock and control
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic timeout_en_i,
    // Link clock
    input wire logic clk_link_i,
    // Bus pins; the clock line is input only
    input wire logic bus_clock_line_i,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_o,
    // Register write stream
    output logic reg_wr_valid_o,
    output sbc_pkg::sbc_wr_s reg_wr_o,
    input wire logic reg_wr_ready_i,
    // Register read request
    output logic reg_rd_req_o,
    output logic [7:0] reg_rd_addr_o,
    input wire logic reg_rd_valid_i,
    input wire logic [7:0] reg_rd_data_i
);
    // Counter must hold the longer of the two limits
    localparam int TO_SPAN = (TIMEOUT_LOW_CYC > sbc_pkg::IDLE_HIGH_CYC) ?
                             TIMEOUT_LOW_CYC : sbc_pkg::IDLE_HIGH_CYC;
    localparam int TO_W = $clog2(TO_SPAN + 1);
    localparam logic [TO_W-1:0] TO_LOW_LIM = TO_W'(TIMEOUT_LOW_CYC - 1);
    localparam logic [TO_W-1:0] TO_IDLE_LIM = TO_W'(sbc_pkg::IDLE_HIGH_CYC);
    localparam logic [TO_W-1:0] TO_MAX = {TO_W{1'b1}};

    // Link-domain synchronisers
    logic lrst_meta, lrst_n, lce_meta, lce;
    logic scl_meta, scl_s, scl_q, sda_meta, sda_s, sda_q;
    logic ten_meta, ten_s, ack_meta, ack_s, ack_q;

    always_ff @(posedge clk_link_i)
    begin
        lrst_meta <= rst_n_i;
        lrst_n <= lrst_meta;
        lce_meta <= clk_en_i;
        lce <= lce_meta;
        scl_meta <= bus_clock_line_i;
        scl_s <= scl_meta;
        scl_q <= scl_s;
        sda_meta <= bus_data_line_i;
        sda_s <= sda_meta;
        sda_q <= sda_s;
        ten_meta <= timeout_en_i;
        ten_s <= ten_meta;
    end

    // Link-domain protocol state
    sbc_pkg::sbc_state_e state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, tx, next_tx, ptr, next_ptr, rd_ptr, next_rd_ptr;
    logic [7:0] rdbuf, next_rdbuf;
    logic dir, next_dir, oe, next_oe, rd_tgl, next_rd_tgl, push, next_push;
    sbc_pkg::sbc_wr_s pdat, next_pdat;
    logic [TO_W-1:0] to_cnt, next_to_cnt;
    logic scl_rise, scl_fall, start, stop, to_fire, fifo_wready;
    logic ack_tgl;
    logic [7:0] rd_data;

    always_comb
    begin
        scl_rise = scl_s && !scl_q;
        scl_fall = !scl_s && scl_q;
        start = scl_s && scl_q && sda_q && !sda_s;
        stop = scl_s && scl_q && !sda_q && sda_s;
        next_to_cnt = (scl_s != scl_q || sda_s != sda_q) ? '0 :
                      (to_cnt == TO_MAX) ? to_cnt : to_cnt + 1'b1;
        to_fire = ten_s && state != sbc_pkg::ST_IDLE &&
                  ((!scl_s && to_cnt >= TO_LOW_LIM) ||
                   (scl_s && sda_s && to_cnt >= TO_IDLE_LIM));
        next_rdbuf = (ack_s != ack_q) ? rd_data : rdbuf;
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_tx = tx;
        next_ptr = ptr;
        next_dir = dir;
        next_oe = oe;
        next_rd_tgl = rd_tgl;
        next_rd_ptr = rd_ptr;
        next_push = 1'b0;
        next_pdat = pdat;
        if (start)
        begin
            // Pointer is kept across a repeated start
            next_state = sbc_pkg::ST_ADDR;
            next_cnt = '0;
            next_oe = 1'b0;
        end
        else if (stop || to_fire)
        begin
            next_state = sbc_pkg::ST_IDLE;
            next_oe = 1'b0;
        end
        else
        begin
            unique case (state)
                sbc_pkg::ST_ADDR, sbc_pkg::ST_PTR, sbc_pkg::ST_WDAT:
                begin
                    if (scl_rise)
                    begin
                        next_sh = {sh[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == sbc_pkg::BYTE_BITS)
                    begin
                        next_cnt = '0;
                        if (state == sbc_pkg::ST_ADDR)
                        begin
                            if (sh[7:1] == sbc_pkg::CLIENT_ADDR)
                            begin
                                next_oe = 1'b1;
                                next_dir = sh[0];
                                next_state = sbc_pkg::ST_ADDR_ACK;
                                if (sh[0])
                                begin
                                    next_rd_tgl = !rd_tgl;
                                    next_rd_ptr = ptr;
                                end
                            end
                            else
                            begin
                                next_state = sbc_pkg::ST_IGNORE;
                            end
                        end
                        else if (state == sbc_pkg::ST_PTR)
                        begin
                            next_ptr = sh;
                            next_oe = 1'b1;
                            next_state = sbc_pkg::ST_PTR_ACK;
                        end
                        else
                        begin
                            // Full buffer: byte is not acknowledged
                            if (fifo_wready)
                            begin
                                next_push = 1'b1;
                                next_pdat = '{addr: ptr, data: sh};
                                next_ptr = ptr + 8'h01;
                                next_oe = 1'b1;
                            end
                            next_state = sbc_pkg::ST_WDAT_ACK;
                        end
                    end
                end
                sbc_pkg::ST_ADDR_ACK, sbc_pkg::ST_PTR_ACK, sbc_pkg::ST_WDAT_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_oe = 1'b0;
                        next_cnt = '0;
                        if (state != sbc_pkg::ST_ADDR_ACK)
                        begin
                            next_state = sbc_pkg::ST_WDAT;
                        end
                        else if (dir)
                        begin
                            next_state = sbc_pkg::ST_RDAT;
                            next_tx = rdbuf;
                            next_oe = !rdbuf[7];
                            next_ptr = ptr + 8'h01;
                        end
                        else
                        begin
                            next_state = sbc_pkg::ST_PTR;
                        end
                    end
                end
                sbc_pkg::ST_RDAT:
                begin
                    if (scl_fall)
                    begin
                        if (cnt == sbc_pkg::LAST_TX_BIT)
                        begin
                            // Release for host answer, prefetch next byte
                            next_oe = 1'b0;
                            next_state = sbc_pkg::ST_RACK;
                            next_rd_tgl = !rd_tgl;
                            next_rd_ptr = ptr;
                        end
                        else
                        begin
                            next_tx = {tx[6:0], 1'b0};
                            next_oe = !tx[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                sbc_pkg::ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        next_sh = {sh[6:0], sda_s};
                    end
                    else if (scl_fall)
                    begin
                        next_cnt = '0;
                        if (!sh[0])
                        begin
                            next_state = sbc_pkg::ST_RDAT;
                            next_tx = rdbuf;
                            next_oe = !rdbuf[7];
                            next_ptr = ptr + 8'h01;
                        end
                        else
                        begin
                            next_state = sbc_pkg::ST_IGNORE;
                        end
                    end
                end
                sbc_pkg::ST_IDLE, sbc_pkg::ST_IGNORE:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_link_i)
    begin
        ack_meta <= ack_tgl;
        ack_s <= ack_meta;
        if (!lrst_n)
        begin
            ack_q <= 1'b0;
            state <= sbc_pkg::ST_IDLE;
            cnt <= '0;
            sh <= sbc_pkg::BYTE_RST;
            tx <= sbc_pkg::BYTE_RST;
            ptr <= sbc_pkg::PTR_RST;
            rd_ptr <= sbc_pkg::PTR_RST;
            rdbuf <= sbc_pkg::BYTE_RST;
            dir <= 1'b0;
            oe <= 1'b0;
            rd_tgl <= 1'b0;
            push <= 1'b0;
            pdat <= '0;
            to_cnt <= '0;
            bus_data_line_o <= 1'b0;
        end
        else if (lce)
        begin
            ack_q <= ack_s;
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            tx <= next_tx;
            ptr <= next_ptr;
            rd_ptr <= next_rd_ptr;
            rdbuf <= next_rdbuf;
            dir <= next_dir;
            oe <= next_oe;
            rd_tgl <= next_rd_tgl;
            push <= next_push;
            pdat <= next_pdat;
            to_cnt <= next_to_cnt;
            bus_data_line_o <= 1'b0;
        end
    end

    // Only the data line is ever driven; clock is never held
    assign bus_data_line_oe_o = oe;

    // Write buffer into the system domain
    logic fifo_rvalid, fifo_rready;
    sbc_pkg::sbc_wr_s fifo_rdata;

    sbc_afifo #(
        .WIDTH($bits(sbc_pkg::sbc_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .wclk_i(clk_link_i),
        .wrst_n_i(lrst_n),
        .wce_i(lce),
        .w_valid_i(push),
        .w_ready_o(fifo_wready),
        .w_data_i(pdat),
        .rclk_i(clk_sys_i),
        .rrst_n_i(rst_n_i),
        .rce_i(clk_en_i),
        .r_valid_o(fifo_rvalid),
        .r_ready_i(fifo_rready),
        .r_data_o(fifo_rdata)
    );

    // System-domain output stage and read handshake
    logic rq_meta, rq_s, rq_q, pend, next_pend, next_ack_tgl;
    logic next_wr_valid, next_rd_req;
    logic [7:0] next_rd_data, next_rd_addr;
    sbc_pkg::sbc_wr_s next_wr;

    always_comb
    begin
        fifo_rready = clk_en_i && (!reg_wr_valid_o || reg_wr_ready_i);
        next_wr_valid = reg_wr_valid_o;
        next_wr = reg_wr_o;
        if (fifo_rready)
        begin
            next_wr_valid = fifo_rvalid;
            next_wr = fifo_rdata;
        end
        next_rd_req = (rq_s != rq_q);
        next_rd_addr = next_rd_req ? rd_ptr : reg_rd_addr_o;
        next_pend = pend || next_rd_req;
        next_rd_data = rd_data;
        next_ack_tgl = ack_tgl;
        if (pend && reg_rd_valid_i)
        begin
            next_rd_data = reg_rd_data_i;
            next_ack_tgl = !ack_tgl;
            next_pend = next_rd_req;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        rq_meta <= rd_tgl;
        rq_s <= rq_meta;
        if (!rst_n_i)
        begin
            rq_q <= 1'b0;
            pend <= 1'b0;
            ack_tgl <= 1'b0;
            rd_data <= sbc_pkg::BYTE_RST;
            reg_rd_req_o <= 1'b0;
            reg_rd_addr_o <= sbc_pkg::PTR_RST;
            reg_wr_valid_o <= 1'b0;
            reg_wr_o <= '0;
        end
        else if (clk_en_i)
        begin
            rq_q <= rq_s;
            pend <= next_pend;
            ack_tgl <= next_ack_tgl;
            rd_data <= next_rd_data;
            reg_rd_req_o <= next_rd_req;
            reg_rd_addr_o <= next_rd_addr;
            reg_wr_valid_o <= next_wr_valid;
            reg_wr_o <= next_wr;
        end
    end
endmodule : sbc_client

// file: bench/sbc_client_sva.sv
// Checker for the client port pins and register streams, bound into sbc_client.
// Assumes the host keeps each clock phase longer than 8 link cycles.
`timescale 1ns/1ps
module sbc_client_sva #(
    parameter int TIMEOUT_LOW_CYC = sbc_pkg::TIMEOUT_LOW_CYC
) (
    // Clocks and control
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic timeout_en_i,
    input wire logic clk_link_i,
    // Bus pins
    input wire logic bus_clock_line_i,
    input wire logic bus_data_line_o,
    input wire logic bus_data_line_oe_o,
    // Register streams
    input wire logic reg_wr_valid_o,
    input wire sbc_pkg::sbc_wr_s reg_wr_o,
    input wire logic reg_wr_ready_i,
    input wire logic reg_rd_req_o,
    input wire logic [7:0] reg_rd_addr_o
);
    int low_cnt;
    int next_low_cnt;
    // Length of the current clock-low phase, saturating
    always_comb
    begin
        next_low_cnt = bus_clock_line_i ? 0 : low_cnt + ((low_cnt < 100000) ? 1 : 0);
    end
    always_ff @(posedge clk_link_i)
    begin
        low_cnt <= next_low_cnt;
    end
    a_data_zero: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        bus_data_line_o == 1'b0) else $error("data pin driven high");
    a_pull_in_low: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        $rose(bus_data_line_oe_o) |-> !bus_clock_line_i && !$past(bus_clock_line_i, 2))
        else $error("data pulled while clock high");
    a_release_in_low: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        $fell(bus_data_line_oe_o) |-> !bus_clock_line_i) else $error("data released in high");
    a_low_timeout: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
        timeout_en_i && low_cnt > TIMEOUT_LOW_CYC + 16 |-> !bus_data_line_oe_o)
        else $error("clock low timeout ignored");
    a_reset_quiet: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> !reg_wr_valid_o && !reg_rd_req_o && reg_rd_addr_o == 8'h00)
        else $error("outputs active in reset");
    a_rd_req_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_rd_req_o |=> !reg_rd_req_o) else $error("read request longer than a cycle");
    a_rd_addr_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !reg_rd_req_o |-> $stable(reg_rd_addr_o)) else $error("read address moved");
    a_wr_word_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_wr_valid_o && !reg_wr_ready_i |=> reg_wr_valid_o && $stable(reg_wr_o))
        else $error("write word dropped or changed");
    c_wr_taken: cover property (@(posedge clk_sys_i) reg_wr_valid_o && reg_wr_ready_i);
    c_rd_req: cover property (@(posedge clk_sys_i) reg_rd_req_o);
    c_pull: cover property (@(posedge clk_link_i) $rose(bus_data_line_oe_o));
endmodule : sbc_client_sva

bind sbc_client sbc_client_sva #(.TIMEOUT_LOW_CYC(TIMEOUT_LOW_CYC)) i_sbc_client_sva (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .timeout_en_i(timeout_en_i),
    .clk_link_i(clk_link_i), .bus_clock_line_i(bus_clock_line_i),
    .bus_data_line_o(bus_data_line_o), .bus_data_line_oe_o(bus_data_line_oe_o),
    .reg_wr_valid_o(reg_wr_valid_o), .reg_wr_o(reg_wr_o), .reg_wr_ready_i(reg_wr_ready_i),
    .reg_rd_req_o(reg_rd_req_o), .reg_rd_addr_o(reg_rd_addr_o)
);

// file: bench/sbc_host_model.sv
// Behavioural bus host: start, stop, byte writes and reads, clock stretching.
// Drives the clock line alone; data is open drain, resolved by the bench.
`timescale 1ns/1ps
module sbc_host_model #(
    parameter int HALF_NS = 2000
) (
    // Bus pins; data pulled low when sda_o is 0
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Data moves only in mid clock-low
    task automatic send_bit(input logic b);
        #(HALF_NS / 2) sda_o = b;
        #(HALF_NS / 2) scl_o = 1'b1;
        #(HALF_NS) scl_o = 1'b0;
    endtask : send_bit
    task automatic rx_bit(input int stretch, output logic b);
        #(HALF_NS / 2) sda_o = 1'b1;
        #(HALF_NS / 2 + stretch) scl_o = 1'b1;
        #(HALF_NS / 2) b = sda_i;
        #(HALF_NS / 2) scl_o = 1'b0;
    endtask : rx_bit
    task automatic bus_start();
        #(HALF_NS / 2) sda_o = 1'b1;
        #(HALF_NS / 2) scl_o = 1'b1;
        #(HALF_NS) sda_o = 1'b0;
        #(HALF_NS) scl_o = 1'b0;
    endtask : bus_start
    task automatic bus_stop();
        #(HALF_NS / 2) sda_o = 1'b0;
        #(HALF_NS / 2) scl_o = 1'b1;
        #(HALF_NS) sda_o = 1'b1;
        #(HALF_NS);
    endtask : bus_stop
    task automatic put_byte(input logic [7:0] d, input int stretch, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--)
            send_bit(d[i]);
        rx_bit(stretch, nack);
        ack = !nack;
    endtask : put_byte
    task automatic get_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            rx_bit(0, d[i]);
        send_bit(!ack);
    endtask : get_byte
    // Clock and data both left high for a while, no start or stop
    task automatic hold_high(input int ns);
        #(HALF_NS / 2) sda_o = 1'b1;
        #(HALF_NS / 2) scl_o = 1'b1;
        #(ns) scl_o = 1'b0;
    endtask : hold_high
endmodule : sbc_host_model

// file: bench/test_sbc_client.sv
// Self-checking bench: host model on the bus, register sink and read responder.
// Read data answered is always the address xor 5A.
`timescale 1ns/1ps
module test_sbc_client;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] dat;
        logic [3:0] n;
        logic rd;
    } sbc_tb_row_s;
    logic clk_sys_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic timeout_en_i = 1'b0;
    logic host_scl;
    logic host_sda;
    logic bus_data;
    logic data_oe;
    logic wr_valid;
    sbc_pkg::sbc_wr_s wr_word;
    logic wr_ready = 1'b0;
    logic sink_stall = 1'b0;
    logic rd_req;
    logic [7:0] rd_addr;
    logic rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [6:0] bad_addr [3] = '{7'h29, 7'h14, 7'h68};
    int failures = 0;
    int comparisons = 0;
    int k;
    logic ack;
    sbc_pkg::sbc_wr_s got_q [$];
    sbc_tb_row_s rows [4] = '{'{8'h10, 8'h3C, 4'h1, 1'b0}, '{8'hFE, 8'hC1, 4'h3, 1'b0},
                              '{8'h20, 8'h00, 4'h1, 1'b1}, '{8'hFE, 8'h00, 4'h3, 1'b1}};
    always #10 clk_sys_i = ~clk_sys_i;
    always #62.5 clk_link_i = ~clk_link_i;
    assign bus_data = host_sda && !data_oe;
    sbc_client #(.TIMEOUT_LOW_CYC(200), .FIFO_DEPTH(sbc_pkg::FIFO_DEPTH)) i_sbc_client (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
        .timeout_en_i(timeout_en_i), .clk_link_i(clk_link_i),
        .bus_clock_line_i(host_scl), .bus_data_line_i(bus_data), .bus_data_line_o(),
        .bus_data_line_oe_o(data_oe), .reg_wr_valid_o(wr_valid), .reg_wr_o(wr_word),
        .reg_wr_ready_i(wr_ready), .reg_rd_req_o(rd_req), .reg_rd_addr_o(rd_addr),
        .reg_rd_valid_i(rd_valid), .reg_rd_data_i(rd_data));
    // Shortest legal clock phases keep the run short
    sbc_host_model #(.HALF_NS(1300)) i_sbc_host_model (.scl_o(host_scl), .sda_o(host_sda),
        .sda_i(bus_data));
    // Sink takes words with ready; responder answers each request next cycle
    always @(negedge clk_sys_i)
    begin
        wr_ready <= !sink_stall;
        if (wr_valid === 1'b1 && !sink_stall)
            got_q.push_back(wr_word);
        rd_valid <= (rd_req === 1'b1);
        rd_data <= rd_addr ^ 8'h5A;
    end
    task automatic give_verdict();
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_words(input int n);
        for (int i = 0; i < 20000 && got_q.size() < n; i++)
            @(negedge clk_sys_i);
        check("word count", 16'(n), 16'(got_q.size()));
        if (got_q.size() < n)
            give_verdict();
    endtask : wait_words
    task automatic put_chk(input logic [7:0] d, input logic exp, input int st);
        logic a;
        i_sbc_host_model.put_byte(d, st, a);
        check("ack", {15'h0000, exp}, {15'h0000, a});
    endtask : put_chk
    task automatic open_wr(input logic [7:0] ptr);
        i_sbc_host_model.bus_start();
        put_chk({sbc_pkg::CLIENT_ADDR, 1'b0}, 1'b1, 0);
        put_chk(ptr, 1'b1, 0);
    endtask : open_wr
    task automatic run_row(input sbc_tb_row_s r);
        logic [7:0] d;
        got_q.delete();
        open_wr(r.ptr);
        if (r.rd)
        begin
            i_sbc_host_model.bus_start();
            put_chk({sbc_pkg::CLIENT_ADDR, 1'b1}, 1'b1, 0);
            for (int i = 0; i < r.n; i++)
            begin
                i_sbc_host_model.get_byte(i < r.n - 1, d);
                check("read byte", {8'h00, (r.ptr + 8'(i)) ^ 8'h5A}, {8'h00, d});
            end
        end
        else
            for (int i = 0; i < r.n; i++)
                put_chk(r.dat + 8'(i), 1'b1, 0);
        i_sbc_host_model.bus_stop();
        if (!r.rd)
            wait_words(r.n);
        for (int i = 0; i < r.n && !r.rd; i++)
            check("write word", {r.ptr + 8'(i), r.dat + 8'(i)}, got_q[i]);
    endtask : run_row
    initial
    begin
        repeat (12) @(negedge clk_link_i);
        @(negedge clk_sys_i);
        check("reset outputs", 16'h0000, {wr_valid, rd_req, data_oe, 5'h00, rd_addr});
        rst_n_i <= 1'b1;
        #1000;
        foreach (rows[i])
            run_row(rows[i]);
        // Foreign and shifted addresses
        got_q.delete();
        foreach (bad_addr[i])
        begin
            i_sbc_host_model.bus_start();
            put_chk({bad_addr[i], 1'b0}, 1'b0, 0);
            put_chk(8'h05, 1'b0, 0);
            i_sbc_host_model.bus_stop();
        end
        check("stray words", 16'h0000, 16'(got_q.size()));
        // Reset in mid-transaction, then recovery
        i_sbc_host_model.bus_start();
        put_chk({sbc_pkg::CLIENT_ADDR, 1'b0}, 1'b1, 0);
        @(negedge clk_sys_i);
        rst_n_i <= 1'b0;
        #1000;
        check("mid reset", 16'h0000, {wr_valid, rd_req, data_oe, 5'h00, rd_addr});
        rst_n_i <= 1'b1;
        #1000;
        i_sbc_host_model.bus_stop();
        run_row(rows[1]);
        // Buffer filled with the sink stalled, drained while clock is held low
        got_q.delete();
        sink_stall <= 1'b1;
        open_wr(8'h40);
        k = 0;
        for (int i = 0; i < 20; i++)
        begin
            i_sbc_host_model.put_byte(8'h80 + 8'(i), 0, ack);
            if (ack === 1'b1 && k == i)
                k++;
        end
        check("taken before full", 16'h0001, 16'(k == 16 || k == 17));
        sink_stall <= 1'b0;
        wait_words(k);
        put_chk(8'hEE, 1'b1, 0);
        i_sbc_host_model.bus_stop();
        wait_words(k + 1);
        for (int i = 0; i < k; i++)
            check("buffered word", {8'h40 + 8'(i), 8'h80 + 8'(i)}, got_q[i]);
        check("word after full", {8'h40 + 8'(k), 8'hEE}, got_q[k]);
        // Long clock low with and without the timeout
        @(negedge clk_sys_i);
        timeout_en_i <= 1'b1;
        i_sbc_host_model.bus_start();
        put_chk({sbc_pkg::CLIENT_ADDR, 1'b0}, 1'b1, 0);
        put_chk(8'h33, 1'b0, 40000);
        i_sbc_host_model.bus_stop();
        // Both lines high in mid-write: port must drop the transfer
        got_q.delete();
        open_wr(8'h60);
        i_sbc_host_model.hold_high(205000);
        put_chk(8'h55, 1'b0, 0);
        i_sbc_host_model.bus_stop();
        check("idle words", 16'h0000, 16'(got_q.size()));
        @(negedge clk_sys_i);
        timeout_en_i <= 1'b0;
        got_q.delete();
        i_sbc_host_model.bus_start();
        put_chk({sbc_pkg::CLIENT_ADDR, 1'b0}, 1'b1, 0);
        put_chk(8'h33, 1'b1, 40000);
        put_chk(8'h99, 1'b1, 0);
        i_sbc_host_model.bus_stop();
        wait_words(1);
        check("stretched write", 16'h3399, got_q[0]);
        give_verdict();
    end
endmodule : test_sbc_client
